// >>> mbs_pkg_crc.sv
// Shared constants and carriers for the function handler, plus the CRC-16 byte step
`default_nettype none

package mbs_pkg;
  // Function codes and exception codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_REGS = 8'h03;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  // Addressing
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ADDR_MAX = 8'h20;
  // Query layout: byte positions within an eight-byte query
  localparam int QUERY_LEN = 8;
  localparam int Q_ADDR = 0;
  localparam int Q_FC = 1;
  localparam int Q_START_HI = 2;
  localparam int Q_START_LO = 3;
  localparam int Q_VAL_HI = 4;
  localparam int Q_VAL_LO = 5;
  // Response layout
  localparam int R_BYTECNT = 2;
  localparam int R_DATA = 3;
  localparam int RESP_MAX = 11;
  localparam int ECHO_LEN = 6;
  localparam int EXC_LEN = 3;
  // Limits on counts per message
  localparam int MAX_RD_COILS = 32;
  localparam int MAX_RD_REGS = 4;
  localparam int BITS_PER_BYTE = 8;
  // Coil change patterns
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // CRC-16, x^16+x^15+x^2+1 in reflected form
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // One byte of a frame with its end marker
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mbs_byte_t;

  // Holding register write event
  typedef struct packed {
    logic valid;
    logic [15:0] num;
    logic [15:0] data;
  } mbs_reg_wr_t;
endpackage : mbs_pkg

`timescale 1ns/1ns

module mbs_crc16
(
  // Running value and input byte
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [15:0] crc_o
);
  always_comb
  begin
    logic [15:0] c;
    c = crc_i ^ {8'h00, data_i};
    for (int b = 0; b < mbs_pkg::BITS_PER_BYTE; b++)
    begin
      c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end
endmodule : mbs_crc16

`default_nettype wire

// >>> mbs_handler.sv
// Modbus-RTU slave handler for read coils, read registers, write coil and write register
// Contract
// - Function 01h reports ON/OFF of consecutive coils from start for count.
// - Start field is item number minus one; device uses it unchanged as the zero-based index.
// - Coil count zero or above 32 answers exception code 03h.
// - Coil response: address, function, byte count, data bytes, two CRC bytes.
// - Eight coils per byte, first coil in LSB, ascending upward.
// - Coils beyond the defined range read as 0 in last byte.
// - Function 03h returns requested consecutive 16-bit holding registers.
// - Byte count is twice register count; each register high byte first.
// - Function 05h writes one coil: FF00h sets ON, 0000h clears OFF.
// - Function 06h stores two-byte value high first into addressed register.
// - Query: address, function, start hi/lo, count or data hi/lo, CRC.
// - Broadcast queries for these functions are not acted upon.
// - Functions that cannot complete answer with an exception response.
// - Successful single writes echo the received query unchanged.
// - Exception response: function plus 80h, exception code, then CRC.
// - Frames end in CRC-16 x^16+x^15+x^2+1; bad-CRC queries dropped.
// - Configured address 1 to 32; mismatching queries silently ignored.
`timescale 1ns/1ns
`default_nettype none

module mbs_handler
#(
  parameter int NUM_COILS = 32,
  parameter int NUM_REGS = 16
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Configuration
  input wire logic [7:0] slave_addr,
  // Query bytes in, silent-interval framing already resolved
  input wire logic rx_valid,
  output logic rx_ready,
  input wire mbs_pkg::mbs_byte_t rx_byte,
  // Response bytes out, CRC appended
  output logic tx_valid,
  input wire logic tx_ready,
  output mbs_pkg::mbs_byte_t tx_byte,
  // Stored device data
  output logic [NUM_COILS-1:0] coil_state,
  output mbs_pkg::mbs_reg_wr_t reg_wr
);
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_CHK = 2'b01,
    ST_TX = 2'b10
  } mbs_st_t;

  typedef struct packed {
    mbs_st_t st;
    logic [3:0] cnt;
    logic [mbs_pkg::QUERY_LEN-1:0][7:0] q;
    logic [15:0] rcrc;
    logic [mbs_pkg::RESP_MAX-1:0][7:0] rb;
    logic [3:0] len;
    logic [3:0] idx;
    logic [7:0] out;
    logic [15:0] tcrc;
    logic [NUM_COILS-1:0] coils;
    logic [NUM_REGS-1:0][15:0] regs;
    mbs_pkg::mbs_reg_wr_t wr;
  } mbs_state_t;
  localparam logic [3:0] QLEN4 = 4'(mbs_pkg::QUERY_LEN);
  mbs_state_t s_q;
  mbs_state_t s_d;
  logic [15:0] rx_crc_n;
  logic [15:0] tx_crc_n;
  mbs_crc16 u_rx_crc
  (
    .crc_i(s_q.rcrc),
    .data_i(rx_byte.data),
    .crc_o(rx_crc_n)
  );

  mbs_crc16 u_tx_crc
  (
    .crc_i(s_q.tcrc),
    .data_i(s_q.out),
    .crc_o(tx_crc_n)
  );

  assign rx_ready = (s_q.st == ST_RX);
  assign tx_valid = (s_q.st == ST_TX);
  assign tx_byte = '{data: s_q.out, last: (s_q.idx == s_q.len + 4'h1)};
  assign coil_state = s_q.coils;
  assign reg_wr = s_q.wr;

  always_comb
  begin
    logic [7:0] fc;
    logic [31:0] start;
    logic [31:0] val;
    logic [31:0] pos;
    logic [mbs_pkg::RESP_MAX-1:0][7:0] nb;
    logic [3:0] nlen;
    logic [7:0] exc;
    logic addr_ok;
    logic known;
    s_d = s_q;
    s_d.wr.valid = 1'b0;
    fc = s_q.q[mbs_pkg::Q_FC];
    start = {16'h0000, s_q.q[mbs_pkg::Q_START_HI], s_q.q[mbs_pkg::Q_START_LO]};
    val = {16'h0000, s_q.q[mbs_pkg::Q_VAL_HI], s_q.q[mbs_pkg::Q_VAL_LO]};
    nb = '0;
    nlen = '0;
    exc = '0;
    pos = '0;
    addr_ok = (slave_addr >= mbs_pkg::SLAVE_ADDR_MIN) && (slave_addr <= mbs_pkg::SLAVE_ADDR_MAX)
      && (s_q.q[mbs_pkg::Q_ADDR] == slave_addr)
      && (s_q.q[mbs_pkg::Q_ADDR] != mbs_pkg::BCAST_ADDR);
    known = (fc == mbs_pkg::FC_RD_COILS) || (fc == mbs_pkg::FC_RD_REGS)
      || (fc == mbs_pkg::FC_WR_COIL) || (fc == mbs_pkg::FC_WR_REG);
    unique case (s_q.st)
      ST_RX:
      begin
        if (rx_valid)
        begin
          if (s_q.cnt < QLEN4)
          begin
            s_d.q[s_q.cnt[2:0]] = rx_byte.data;
          end
          if (s_q.cnt <= QLEN4)
          begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
          s_d.rcrc = rx_crc_n;
          if (rx_byte.last)
          begin
            s_d.st = ST_CHK;
          end
        end
      end
      ST_CHK:
      begin
        s_d.cnt = '0;
        s_d.rcrc = mbs_pkg::CRC_INIT;
        s_d.st = ST_RX;
        // Drop on CRC failure, foreign or broadcast address, or bad length for a known function code
        if ((s_q.rcrc == mbs_pkg::CRC_GOOD) && addr_ok
            && !(known && (s_q.cnt != QLEN4)))
        begin
          nb[mbs_pkg::Q_ADDR] = s_q.q[mbs_pkg::Q_ADDR];
          nb[mbs_pkg::Q_FC] = fc;
          if (!known)
          begin
            exc = mbs_pkg::EXC_BAD_FUNC;
          end
          else if (fc == mbs_pkg::FC_RD_COILS)
          begin
            if ((val == 32'h0) || (val > 32'(mbs_pkg::MAX_RD_COILS)))
            begin
              exc = mbs_pkg::EXC_BAD_DATA;
            end
            else
            begin
              nb[mbs_pkg::R_BYTECNT] = 8'((val + 32'h7) >> 3);
              // Start field is already the zero-based index of coil start+1
              for (int k = 0; k < mbs_pkg::MAX_RD_COILS; k++)
              begin
                pos = start + 32'(k);
                nb[mbs_pkg::R_DATA + k / mbs_pkg::BITS_PER_BYTE][k % mbs_pkg::BITS_PER_BYTE] =
                  (32'(k) < val) && (pos < 32'(NUM_COILS)) && s_q.coils[pos];
              end
              nlen = 4'(mbs_pkg::R_DATA) + nb[mbs_pkg::R_BYTECNT][3:0];
            end
          end
          else if (fc == mbs_pkg::FC_RD_REGS)
          begin
            if ((val == 32'h0) || (val > 32'(mbs_pkg::MAX_RD_REGS)))
            begin
              exc = mbs_pkg::EXC_BAD_DATA;
            end
            else if (start + val > 32'(NUM_REGS))
            begin
              exc = mbs_pkg::EXC_BAD_ADDR;
            end
            else
            begin
              nb[mbs_pkg::R_BYTECNT] = 8'(val << 1);
              for (int r = 0; r < mbs_pkg::MAX_RD_REGS; r++)
              begin
                if (32'(r) < val)
                begin
                  pos = start + 32'(r);
                  nb[mbs_pkg::R_DATA + 2 * r] = s_q.regs[pos][15:8];
                  nb[mbs_pkg::R_DATA + 2 * r + 1] = s_q.regs[pos][7:0];
                end
              end
              nlen = 4'(mbs_pkg::R_DATA) + nb[mbs_pkg::R_BYTECNT][3:0];
            end
          end
          else if (fc == mbs_pkg::FC_WR_COIL)
          begin
            if (start >= 32'(NUM_COILS))
            begin
              exc = mbs_pkg::EXC_BAD_ADDR;
            end
            else if ((val[15:0] != mbs_pkg::COIL_ON) && (val[15:0] != mbs_pkg::COIL_OFF))
            begin
              exc = mbs_pkg::EXC_BAD_DATA;
            end
            else
            begin
              s_d.coils[start] = (val[15:0] == mbs_pkg::COIL_ON);
            end
          end
          else
          begin
            if (start >= 32'(NUM_REGS))
            begin
              exc = mbs_pkg::EXC_BAD_ADDR;
            end
            else
            begin
              s_d.regs[start] = val[15:0];
              s_d.wr = '{valid: 1'b1, num: start[15:0], data: val[15:0]};
            end
          end
          if ((fc == mbs_pkg::FC_WR_COIL) || (fc == mbs_pkg::FC_WR_REG))
          begin
            for (int e = 0; e < mbs_pkg::ECHO_LEN; e++)
            begin
              nb[e] = s_q.q[e];
            end
            nlen = 4'(mbs_pkg::ECHO_LEN);
          end
          if (exc != 8'h00)
          begin
            nb = '0;
            nb[mbs_pkg::Q_ADDR] = s_q.q[mbs_pkg::Q_ADDR];
            nb[mbs_pkg::Q_FC] = fc | mbs_pkg::EXC_FLAG;
            nb[mbs_pkg::R_BYTECNT] = exc;
            nlen = 4'(mbs_pkg::EXC_LEN);
            s_d.coils = s_q.coils;
            s_d.regs = s_q.regs;
            s_d.wr.valid = 1'b0;
          end
          s_d.rb = nb;
          s_d.len = nlen;
          s_d.idx = '0;
          s_d.out = nb[0];
          s_d.tcrc = mbs_pkg::CRC_INIT;
          s_d.st = ST_TX;
        end
      end
      ST_TX:
      begin
        if (tx_ready)
        begin
          s_d.idx = s_q.idx + 4'h1;
          if (s_q.idx < s_q.len)
          begin
            s_d.tcrc = tx_crc_n;
          end
          // Payload, then CRC low byte, then CRC high byte
          if (s_q.idx + 4'h1 < s_q.len)
          begin
            s_d.out = s_q.rb[s_q.idx + 4'h1];
          end
          else if (s_q.idx + 4'h1 == s_q.len)
          begin
            s_d.out = tx_crc_n[7:0];
          end
          else
          begin
            s_d.out = s_q.tcrc[15:8];
          end
          if (s_q.idx == s_q.len + 4'h1)
          begin
            s_d.st = ST_RX;
          end
        end
      end
      default:
      begin
        s_d.st = ST_RX;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '{st: ST_RX, rcrc: mbs_pkg::CRC_INIT, tcrc: mbs_pkg::CRC_INIT, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule : mbs_handler

`default_nettype wire

// >>> mbs_handler_monitor.sv
// Concurrent checks on the function handler ports
`timescale 1ns/1ns
`default_nettype none

module mbs_handler_monitor
#(
  parameter int NUM_COILS = 32,
  parameter int NUM_REGS = 16
)
(
  // Clock, reset, configuration
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] slave_addr,
  // Query stream
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire mbs_pkg::mbs_byte_t rx_byte,
  // Response stream
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire mbs_pkg::mbs_byte_t tx_byte,
  // Stored data
  input wire logic [NUM_COILS-1:0] coil_state,
  input wire mbs_pkg::mbs_reg_wr_t reg_wr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence q_end;
    rx_valid && rx_ready && rx_byte.last;
  endsequence
  sequence exc_head;
    $rose(tx_valid) && tx_ready ##1 tx_ready && tx_byte.data[7] ##1 tx_ready;
  endsequence

  a_query_close: assert property (q_end |=> !rx_ready && !tx_valid ##1 tx_valid || rx_ready)
    else $error("query end not followed by answer or release");
  a_resp_addr: assert property ($rose(tx_valid) |-> tx_byte.data == slave_addr
    && slave_addr inside {[8'h01:8'h20]})
    else $error("response from wrong or invalid address");
  a_exc_code: assert property (exc_head |-> tx_byte.data inside {8'h01, 8'h02, 8'h03}
    ##1 !tx_byte.last)
    else $error("exception frame malformed");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("response byte changed while stalled");
  a_last_end: assert property (tx_valid && tx_ready && tx_byte.last |=> !tx_valid && rx_ready)
    else $error("frame did not end after last byte");
  a_one_query: assert property ($fell(rx_ready) |-> $past(rx_valid) && $past(rx_byte.last))
    else $error("query intake stopped before last byte");
  a_reg_pulse: assert property (reg_wr.valid |-> tx_valid && reg_wr.num < NUM_REGS
    ##1 !reg_wr.valid)
    else $error("register write pulse wrong");
  a_coil_when: assert property (!$stable(coil_state) |-> $rose(tx_valid)
    && $past(rx_ready) == 1'b0)
    else $error("coil changed outside a write");
  a_coil_one: assert property (!$stable(coil_state) |->
    $onehot(coil_state ^ $past(coil_state)))
    else $error("more than one coil changed");
endmodule : mbs_handler_monitor

`default_nettype wire

// >>> mbs_host_model.sv
// Host master model: sends framed queries and collects responses
`timescale 1ns/1ns
`default_nettype none

module mbs_host_model
(
  // Clock
  input wire logic core_clk,
  // Query side
  output var logic rx_valid,
  input wire logic rx_ready,
  output var mbs_pkg::mbs_byte_t rx_byte,
  // Response side
  input wire logic tx_valid,
  output var logic tx_ready,
  input wire mbs_pkg::mbs_byte_t tx_byte
);
  logic [7:0] got [$];
  logic stall = 1'b0;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte = '0;
    tx_ready = 1'b1;
  end

  function automatic logic [15:0] crc16(input logic [79:0] v, input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ {8'h00, v[79-8*i -: 8]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16

  // Caller gives start field already as item number minus one
  task automatic send(input logic [47:0] q, input logic bad);
    logic [15:0] c;
    logic [63:0] f;
    c = crc16({q, 32'h0}, 6) ^ {15'h0, bad};
    f = {q, c[7:0], c[15:8]};
    rx_valid = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rx_byte = '{f[63-8*i -: 8], i == 7};
      for (int k = 0; k < 50 && !rx_ready; k++)
        @(posedge core_clk) #1;
      stall = stall | !rx_ready;
      @(posedge core_clk) #1;
    end
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask : send

  // Slow mode accepts every other cycle
  task automatic get(input logic slow);
    got = {};
    for (int k = 0; k < 100; k++)
    begin
      @(posedge core_clk) #1;
      tx_ready = !slow || k[0];
      if (tx_valid && tx_ready)
      begin
        got.push_back(tx_byte.data);
        if (tx_byte.last)
          break;
      end
    end
  endtask : get
endmodule : mbs_host_model

`default_nettype wire

// >>> mbs_handler_bench.sv
// Self-checking bench for the function handler
`timescale 1ns/1ns
`default_nettype none

module mbs_handler_bench;
  typedef struct {logic [47:0] q; logic [55:0] r; int n;} mbs_row_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] slave_addr = 8'h08;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  mbs_pkg::mbs_byte_t rx_byte, tx_byte;
  logic [31:0] coil_state;
  mbs_pkg::mbs_reg_wr_t reg_wr;
  int n_errors = 0;
  int check_count = 0;
  int wr_count = 0;
  logic [31:0] wr_seen = '0;
  mbs_row_t rows [18];

  always #2 core_clk = ~core_clk;

  // Capture register write pulses
  always @(posedge core_clk)
  begin
    if (reg_wr.valid)
    begin
      wr_seen <= {reg_wr.num, reg_wr.data};
      wr_count <= wr_count + 1;
    end
  end

  mbs_handler #(.NUM_COILS(32), .NUM_REGS(16)) dut (.core_clk, .resetn, .slave_addr,
    .rx_valid, .rx_ready, .rx_byte, .tx_valid, .tx_ready, .tx_byte, .coil_state, .reg_wr);

  mbs_host_model host (.core_clk, .rx_valid, .rx_ready, .rx_byte, .tx_valid, .tx_ready,
    .tx_byte);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Zero payload length means no response is due
  task automatic run(input logic [47:0] q, input logic [55:0] r, input int n,
    input logic slow, input logic bad);
    logic [15:0] c;
    logic [7:0] e;
    c = host.crc16({r, 24'h0}, n);
    host.send(q, bad);
    host.get(slow);
    chk("stall", 32'h0, 32'(host.stall));
    chk("length", n > 0 ? n + 2 : 0, host.got.size());
    for (int j = 0; j < n + 2 && j < host.got.size(); j++)
    begin
      e = j < n ? r[55-8*j -: 8] : (j == n ? c[7:0] : c[15:8]);
      chk("byte", 32'(e), 32'(host.got[j]));
    end
  endtask : run

  task automatic final_report;
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  initial
  begin
    rows = '{
      '{48'h080500_06ff00, 56'h08050006ff0000, 6}, '{48'h080500_00ff00, 56'h08050000ff0000, 6},
      '{48'h080500_1fff00, 56'h0805001fff0000, 6}, '{48'h080100_00000a, 56'h08010241000000, 5},
      '{48'h080100_1e0004, 56'h08010102000000, 4}, '{48'h080100_000020, 56'h08010441000080, 7},
      '{48'h080100_000000, 56'h08810300000000, 3}, '{48'h080100_000021, 56'h08810300000000, 3},
      '{48'h080600_021234, 56'h08060002123400, 6}, '{48'h080300_010002, 56'h08030400001234, 7},
      '{48'h080300_000005, 56'h08830300000000, 3}, '{48'h080300_0f0002, 56'h08830200000000, 3},
      '{48'h080300_0e0002, 56'h08030400000000, 7}, '{48'h080500_001234, 56'h08850300000000, 3},
      '{48'h080500_000000, 56'h08050000000000, 6}, '{48'h080100_000008, 56'h08010140000000, 4},
      '{48'h080700_000000, 56'h08870100000000, 3}, '{48'h080500_20ff00, 56'h08850200000000, 3}};
    repeat (10) @(posedge core_clk);
    chk("rx_ready", 32'h1, rx_ready);
    chk("tx_valid", 32'h0, tx_valid);
    chk("coils", 32'h0, coil_state);
    #1 resetn = 1'b1;
    foreach (rows[i])
      run(rows[i].q, rows[i].r, rows[i].n, i[0], 1'b0);
    chk("coils", 32'h80000040, coil_state);
    chk("reg_wr", 32'h00021234, wr_seen);
    chk("wr_count", 32'h1, 32'(wr_count));
    run(48'h000500_01ff00, 56'h0, 0, 1'b0, 1'b0);
    run(48'h090500_01ff00, 56'h0, 0, 1'b0, 1'b0);
    run(48'h080500_01ff00, 56'h0, 0, 1'b0, 1'b1);
    slave_addr = 8'h21;
    run(48'h210500_01ff00, 56'h0, 0, 1'b0, 1'b0);
    slave_addr = 8'h08;
    chk("coils", 32'h80000040, coil_state);
    // Reset in mid-run clears coils and holding registers
    @(posedge core_clk) #1 resetn = 1'b0;
    @(posedge core_clk) #1;
    chk("coils", 32'h0, coil_state);
    chk("tx_valid", 32'h0, 32'(tx_valid));
    resetn = 1'b1;
    run(48'h080300_020001, 56'h08030200000000, 5, 1'b1, 1'b0);
    final_report();
  end
endmodule : mbs_handler_bench

bind mbs_handler mbs_handler_monitor #(.NUM_COILS(NUM_COILS), .NUM_REGS(NUM_REGS)) mon (
  .core_clk, .resetn, .slave_addr, .rx_valid, .rx_ready, .rx_byte, .tx_valid, .tx_ready,
  .tx_byte, .coil_state, .reg_wr);

`default_nettype wire
